//--- rtl/cnd_pkg.sv
// Package for the CANopen object dispatch block: identifiers, commands, states, timing.
// Assumes a CAN controller outside that hands over received frames and sends frames on request.
package cnd_pkg;

	// Frame and identifier widths.
	localparam int COB_W  = 11;
	localparam int DLC_W  = 4;
	localparam int NODE_W = 8;

	// Largest data field of a frame and the fixed emergency and boot-up lengths, in bytes.
	localparam logic [3:0] MAX_BYTES = 4'h8;
	localparam logic [3:0] EMCY_BYTES = 4'h8;
	localparam logic [3:0] BOOT_BYTES = 4'h1;

	// Fixed identifiers and the base values of the predefined connection set.
	localparam logic [10:0] COB_NMT      = 11'h000;
	localparam logic [10:0] COB_SYNC     = 11'h080;
	localparam logic [10:0] BASE_EMCY    = 11'h080;
	localparam logic [10:0] BASE_TPDO1   = 11'h180;
	localparam logic [10:0] BASE_RPDO1   = 11'h200;
	localparam logic [10:0] BASE_TPDO2   = 11'h280;
	localparam logic [10:0] BASE_RPDO2   = 11'h300;
	localparam logic [10:0] BASE_TPDO3   = 11'h380;
	localparam logic [10:0] BASE_RPDO3   = 11'h400;
	localparam logic [10:0] BASE_TPDO4   = 11'h480;
	localparam logic [10:0] BASE_RPDO4   = 11'h500;
	localparam logic [10:0] BASE_TSDO    = 11'h580;
	localparam logic [10:0] BASE_RSDO    = 11'h600;
	localparam logic [10:0] BASE_GUARD   = 11'h700;
	localparam logic [10:0] RANGE_SPAN   = 11'h07f;

	// Node identifier limits.
	localparam logic [7:0] NODE_MIN = 8'h01;
	localparam logic [7:0] NODE_MAX = 8'h7f;
	localparam logic [7:0] NODE_ALL = 8'h00;

	// Management command specifiers.
	localparam logic [7:0] CS_START    = 8'h01;
	localparam logic [7:0] CS_STOP     = 8'h02;
	localparam logic [7:0] CS_PREOP    = 8'h80;
	localparam logic [7:0] CS_RST_NODE = 8'h81;
	localparam logic [7:0] CS_RST_COMM = 8'h82;
	localparam logic [7:0] BOOT_DATA   = 8'h00;

	// Transmission modes of the transmit process-data object.
	localparam logic [1:0] MODE_EVENT   = 2'h0;
	localparam logic [1:0] MODE_SYNC_CY = 2'h1;
	localparam logic [1:0] MODE_SYNC_AC = 2'h2;

	// Time spent in initialisation before the node moves to pre-operational.
	localparam int CLK_MHZ     = 100;
	localparam int INIT_NS     = 1000;
	localparam int INIT_CYCLES = (INIT_NS * CLK_MHZ + 999) / 1000;

	// Management states, one-hot.
	typedef enum logic [3:0] {
		ST_INIT   = 4'h1,
		ST_PREOP  = 4'h2,
		ST_OPER   = 4'h4,
		ST_STOP   = 4'h8
	} cnd_state_e;

	// One CAN data frame.
	typedef struct packed {
		logic [10:0] cob;
		logic        rtr;
		logic [3:0]  dlc;
		logic [63:0] data;
	} cnd_frame_s;

endpackage

//--- rtl/cnd_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module cnd_fifo #(
	parameter int WIDTH = 80,
	parameter int DEPTH = 32
) (
	input  wire logic             clk_sys,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	// Full and empty come straight from the fill count.
	assign in_ready  = (count != DEPTH[AW:0]);
	assign out_valid = (count != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr];

	// Storage write.
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// Pointers and fill count.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule

//--- rtl/cnd_dispatch.sv
// CANopen slave object dispatch: management states, identifiers and frame triggers.
// Assumes a CAN controller that delivers received frames as one-cycle strobes
// and takes transmit frames through a valid/ready handshake.
`timescale 1ns/10ps
module cnd_dispatch #(
	parameter int TIMER_CYCLES = 100000,
	parameter int FIFO_DEPTH   = 32
) (
	input  wire logic                clk_sys,
	input  wire logic                reset,
	input  wire logic [7:0]          node_switch,
	input  wire cnd_pkg::cnd_frame_s rx_frame,
	input  wire logic                rx_valid,
	input  wire logic [1:0]          tpdo_mode,
	input  wire logic                timer_en,
	input  wire logic [63:0]         tpdo_data,
	input  wire logic [3:0]          tpdo_len,
	input  wire logic                input_event,
	input  wire logic                app_event,
	input  wire logic                error_event,
	input  wire logic [15:0]         error_code,
	input  wire logic [7:0]          error_reg,
	input  wire logic                sdo_tx_valid,
	input  wire logic [63:0]         sdo_tx_data,
	output logic                     sdo_tx_ready,
	output cnd_pkg::cnd_frame_s      sdo_rx_frame,
	output logic                     sdo_rx_valid,
	output cnd_pkg::cnd_frame_s      rpdo_frame,
	output logic                     rpdo_valid,
	output cnd_pkg::cnd_frame_s      tx_frame,
	output logic                     tx_valid,
	input  wire logic                tx_ready,
	output cnd_pkg::cnd_state_e      nmt_state,
	output logic [7:0]               node_id,
	output logic                     node_id_bad,
	output logic                     sync_seen
);
	localparam int FW = $bits(cnd_pkg::cnd_frame_s);

	// Adds a node identifier to a base identifier.
	function automatic logic [10:0] cob_of(input logic [10:0] base, input logic [7:0] id);
		cob_of = base + {4'h0, id[6:0]};
	endfunction

	// True when an identifier lies in the node's slot of a range.
	function automatic logic hits(input logic [10:0] cob, input logic [10:0] base,
			input logic [7:0] id);
		hits = (cob == cob_of(base, id));
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Switch synchroniser and node identifier capture.

	logic [7:0] sw_s1;
	logic [7:0] sw_s2;
	logic [7:0] sw_s3;
	logic [15:0] init_cnt;
	logic       init_done;
	logic       reinit;

	// Three stages; a value counts when the last two agree.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sw_s1 <= '0;
			sw_s2 <= '0;
			sw_s3 <= '0;
		end else begin
			sw_s1 <= node_switch;
			sw_s2 <= sw_s1;
			sw_s3 <= sw_s2;
		end
	end

	// The identifier is latched while initialising, from a settled switch byte.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			node_id     <= cnd_pkg::NODE_ALL;
			node_id_bad <= 1'b1;
		end else if (nmt_state == cnd_pkg::ST_INIT && sw_s2 == sw_s3) begin
			node_id     <= sw_s3;
			node_id_bad <= (sw_s3 < cnd_pkg::NODE_MIN) || (sw_s3 > cnd_pkg::NODE_MAX);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Management state machine.

	logic       nmt_hit;
	logic [7:0] nmt_cs;
	logic       boot_pend;
	logic       boot_take;
	logic       emcy_take;
	logic       pdo_take;

	assign nmt_cs  = rx_frame.data[63:56];
	// Specifier first, target second; zero addresses every node.
	assign nmt_hit = rx_valid && !rx_frame.rtr && rx_frame.cob == cnd_pkg::COB_NMT
		&& (rx_frame.data[55:48] == node_id || rx_frame.data[55:48] == cnd_pkg::NODE_ALL);
	assign reinit  = nmt_hit && (nmt_cs == cnd_pkg::CS_RST_NODE || nmt_cs == cnd_pkg::CS_RST_COMM);
	assign init_done = (init_cnt == 16'(cnd_pkg::INIT_CYCLES - 1)) && !node_id_bad;

	// Initialisation time counter.
	always_ff @(posedge clk_sys) begin
		if (reset || reinit || nmt_state != cnd_pkg::ST_INIT) begin
			init_cnt <= '0;
		end else if (init_cnt != 16'(cnd_pkg::INIT_CYCLES - 1)) begin
			init_cnt <= init_cnt + 16'h0001;
		end
	end

	// State transitions; reset commands act in every state, the others only outside initialisation; the master paces them.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			nmt_state <= cnd_pkg::ST_INIT;
		end else if (reinit) begin
			nmt_state <= cnd_pkg::ST_INIT;
		end else if (nmt_state == cnd_pkg::ST_INIT) begin
			if (init_done) begin
				nmt_state <= cnd_pkg::ST_PREOP;
			end
		end else if (nmt_hit) begin
			unique case (nmt_cs)
				cnd_pkg::CS_START: nmt_state <= cnd_pkg::ST_OPER;
				cnd_pkg::CS_PREOP: nmt_state <= cnd_pkg::ST_PREOP;
				cnd_pkg::CS_STOP:  nmt_state <= cnd_pkg::ST_STOP;
				default:           nmt_state <= nmt_state;
			endcase
		end
	end

	// A reset command owes a boot-up frame once initialisation ends.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			boot_pend <= 1'b0;
		end else if (reinit) begin
			boot_pend <= 1'b1;
		end else if (boot_take) begin
			boot_pend <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Received frame sorting.

	logic oper;
	logic talk;

	assign oper = (nmt_state == cnd_pkg::ST_OPER);
	assign talk = oper || nmt_state == cnd_pkg::ST_PREOP;

	// Service data in both talking states, process data only when operational.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sdo_rx_valid <= 1'b0;
			rpdo_valid   <= 1'b0;
			sync_seen    <= 1'b0;
			sdo_rx_frame <= '0;
			rpdo_frame   <= '0;
		end else begin
			sdo_rx_valid <= rx_valid && talk && !rx_frame.rtr
				&& hits(rx_frame.cob, cnd_pkg::BASE_RSDO, node_id);
			rpdo_valid   <= rx_valid && oper && !rx_frame.rtr
				&& rx_frame.dlc <= cnd_pkg::MAX_BYTES
				&& hits(rx_frame.cob, cnd_pkg::BASE_RPDO1, node_id);
			sync_seen    <= rx_valid && !rx_frame.rtr && rx_frame.cob == cnd_pkg::COB_SYNC;
			sdo_rx_frame <= rx_frame;
			rpdo_frame   <= rx_frame;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transmit process-data triggers.

	logic [31:0] tmr;
	logic        tmr_hit;
	logic        pdo_req;
	logic        rtr_hit;
	logic [63:0] held;
	logic [3:0]  held_len;

	assign tmr_hit = timer_en && tmr == 32'(TIMER_CYCLES - 1);
	assign rtr_hit = rx_valid && rx_frame.rtr && hits(rx_frame.cob, cnd_pkg::BASE_TPDO1, node_id);

	// Periodic timer for event mode.
	always_ff @(posedge clk_sys) begin
		if (reset || !timer_en || tmr_hit) begin
			tmr <= '0;
		end else begin
			tmr <= tmr + 32'h0000_0001;
		end
	end

	// Inputs are sampled on the trigger; the frame is queued afterwards.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pdo_req  <= 1'b0;
			held     <= '0;
			held_len <= '0;
		end else if (!oper) begin
			pdo_req  <= 1'b0;
		end else if ((tpdo_mode == cnd_pkg::MODE_EVENT && (input_event || tmr_hit))
				|| (tpdo_mode == cnd_pkg::MODE_SYNC_CY && sync_seen)
				|| (tpdo_mode == cnd_pkg::MODE_SYNC_AC && app_event)
				|| (tpdo_mode != cnd_pkg::MODE_SYNC_CY && rtr_hit)) begin
			pdo_req  <= 1'b1;
			held     <= tpdo_data;
			held_len <= (tpdo_len > cnd_pkg::MAX_BYTES) ? cnd_pkg::MAX_BYTES : tpdo_len;
		end else if (pdo_take) begin
			pdo_req  <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Emergency producer.

	logic        err_d;
	logic        emcy_req;
	logic [63:0] emcy_data;

	// Only the rising edge of an error counts, so a lasting error sends once.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			err_d     <= 1'b0;
			emcy_req  <= 1'b0;
			emcy_data <= '0;
		end else begin
			err_d <= error_event;
			if (error_event && !err_d && talk) begin
				emcy_req  <= 1'b1;
				emcy_data <= {error_code[7:0], error_code[15:8], error_reg, 40'h0};
			end else if (emcy_take) begin
				emcy_req  <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transmit arbiter into the FIFO: boot-up, emergency, process data, service data.

	logic              sdo_take;
	logic              q_ready;
	cnd_pkg::cnd_frame_s q_frame;
	logic              q_valid;

	assign boot_take = q_ready && boot_pend && nmt_state == cnd_pkg::ST_PREOP;
	assign emcy_take = q_ready && !boot_take && emcy_req;
	assign pdo_take  = q_ready && !boot_take && !emcy_req && pdo_req && oper;
	assign sdo_take  = q_ready && !boot_take && !emcy_req && !(pdo_req && oper)
		&& sdo_tx_valid && talk;
	assign sdo_tx_ready = sdo_take;
	assign q_valid = boot_take || emcy_take || pdo_take || sdo_take;

	// Frame build for the winner.
	always_comb begin
		q_frame = '0;
		if (boot_take) begin
			q_frame.cob  = cob_of(cnd_pkg::BASE_GUARD, node_id);
			q_frame.dlc  = cnd_pkg::BOOT_BYTES;
			q_frame.data = {cnd_pkg::BOOT_DATA, 56'h0};
		end else if (emcy_take) begin
			q_frame.cob  = cob_of(cnd_pkg::BASE_EMCY, node_id);
			q_frame.dlc  = cnd_pkg::EMCY_BYTES;
			q_frame.data = emcy_data;
		end else if (pdo_take) begin
			q_frame.cob  = cob_of(cnd_pkg::BASE_TPDO1, node_id);
			q_frame.dlc  = held_len;
			q_frame.data = held;
		end else if (sdo_take) begin
			q_frame.cob  = cob_of(cnd_pkg::BASE_TSDO, node_id);
			q_frame.dlc  = cnd_pkg::MAX_BYTES;
			q_frame.data = sdo_tx_data;
		end
	end

	// Outgoing frames queue here while the controller is busy.
	cnd_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_txq (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.in_data  (q_frame),
		.in_valid (q_valid),
		.in_ready (q_ready),
		.out_data (tx_frame),
		.out_valid(tx_valid),
		.out_ready(tx_ready)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	pdo_gate_a: assert property (@(posedge clk_sys) disable iff (reset)
		pdo_take |-> nmt_state == cnd_pkg::ST_OPER) else $error("PDO queued outside Operational.");

	pdo_len_a: assert property (@(posedge clk_sys) disable iff (reset)
		pdo_take |-> q_frame.dlc <= cnd_pkg::MAX_BYTES) else $error("PDO longer than eight bytes.");

	emcy_once_a: assert property (@(posedge clk_sys) disable iff (reset)
		emcy_take && !(error_event && !err_d && talk) |=> !emcy_req)
		else $error("Emergency sent twice for one error.");

	emcy_cob_a: assert property (@(posedge clk_sys) disable iff (reset)
		emcy_take |-> q_frame.cob == node_id + cnd_pkg::BASE_EMCY
		&& q_frame.dlc == cnd_pkg::EMCY_BYTES)
		else $error("Emergency identifier or length wrong.");

	nmt_start_a: assert property (@(posedge clk_sys) disable iff (reset)
		nmt_hit && nmt_cs == cnd_pkg::CS_START && nmt_state != cnd_pkg::ST_INIT
		|=> nmt_state == cnd_pkg::ST_OPER) else $error("Start command not obeyed.");

	reset_cmd_a: assert property (@(posedge clk_sys) disable iff (reset)
		reinit |=> nmt_state == cnd_pkg::ST_INIT && boot_pend) else $error("Reset command not obeyed.");

	boot_frame_a: assert property (@(posedge clk_sys) disable iff (reset)
		boot_take |-> q_frame.dlc == cnd_pkg::BOOT_BYTES
		&& q_frame.cob == cnd_pkg::BASE_GUARD + node_id)
		else $error("Boot-up frame malformed.");

	sync_rx_a: assert property (@(posedge clk_sys) disable iff (reset)
		rx_valid && !rx_frame.rtr && rx_frame.cob == cnd_pkg::COB_SYNC |=> sync_seen)
		else $error("Sync frame not recognised.");

	init_exit_a: assert property (@(posedge clk_sys) disable iff (reset)
		$past(nmt_state) == cnd_pkg::ST_INIT && nmt_state != cnd_pkg::ST_INIT
		|-> nmt_state == cnd_pkg::ST_PREOP) else $error("Initialization left to wrong state.");

	sdo_gate_a: assert property (@(posedge clk_sys) disable iff (reset)
		sdo_rx_valid |-> $past(talk)) else $error("Service frame passed while silent.");

	node_range_a: assert property (@(posedge clk_sys) disable iff (reset)
		nmt_state != cnd_pkg::ST_INIT |-> !node_id_bad && node_id >= cnd_pkg::NODE_MIN
		&& node_id <= cnd_pkg::NODE_MAX) else $error("Node runs with a bad identifier.");

endmodule

//--- verif/cnd_master.sv
// Network manager model on the CAN side of the dispatch block.
// Assumes clk_sys at 100 MHz; it changes its outputs one time unit after a rising edge.
`timescale 1ns/10ps
module cnd_master #(
	// Twenty milliseconds at 100 MHz; the bench shortens it, as the block needs no pause.
	parameter int PAUSE = 2000000
) (
	input  wire logic                clk_sys,
	input  wire logic                hold,
	input  wire cnd_pkg::cnd_frame_s tx_frame,
	input  wire logic                tx_valid,
	output cnd_pkg::cnd_frame_s      rx_frame,
	output logic                     rx_valid,
	output logic                     tx_ready
);
	cnd_pkg::cnd_frame_s got[$];

	////////////////////////////////////////
	// Idle bus at time zero.
	initial begin
		rx_frame = '0;
		rx_valid = 1'b0;
		tx_ready = 1'b1;
	end

	// Frames are taken on valid and ready; ready then follows the stall request.
	always @(posedge clk_sys) begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1)
			got.push_back(tx_frame);
		#1 tx_ready = !hold;
	end

	////////////////////////////////////////
	// One received frame, held for exactly one edge.
	task automatic send(input logic [10:0] cob, input logic rtr, input logic [3:0] dlc,
			input logic [63:0] data);
		@(posedge clk_sys);
		#1;
		rx_frame = '{cob: cob, rtr: rtr, dlc: dlc, data: data};
		rx_valid = 1'b1;
		@(posedge clk_sys);
		#1;
		rx_valid = 1'b0;
		rx_frame = ~rx_frame; // Released bus shows no stale frame.
	endtask

	// A management command, then the pause before the next request.
	task automatic nmt(input logic [7:0] cs, input logic [7:0] target);
		send(cnd_pkg::COB_NMT, 1'b0, 4'h2, {cs, target, 48'h0});
		repeat (PAUSE) @(posedge clk_sys);
		#1;
	endtask
endmodule

//--- verif/test_canopen_nmt_object_dispatch.sv
// Self-checking bench for the object dispatch block with a network manager model.
// Assumes the package and the design files are compiled first.
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; $display("mismatch at %0t: got %h expected %h", $time, (a), (b)); end end
module test_canopen_nmt_object_dispatch;
	logic                clk_sys = 1'b0;
	logic                reset = 1'b1;
	logic                hold = 1'b0;
	logic [7:0]          node_switch, id, cs;
	logic [1:0]          tpdo_mode = 2'h0;
	logic                timer_en = 1'b0, input_event = 1'b0, app_event = 1'b0;
	logic                error_event = 1'b0, sdo_tx_valid = 1'b0, rx_valid, tx_valid, tx_ready;
	logic [63:0]         tpdo_data = 64'h0, sdo_tx_data = 64'h0;
	logic [3:0]          tpdo_len = 4'h8;
	logic [15:0]         error_code = 16'h0;
	logic [7:0]          error_reg = 8'h0;
	logic                sdo_tx_ready, sdo_rx_valid, rpdo_valid, node_id_bad, sync_seen;
	logic [7:0]          node_id;
	logic [31:0]         seed = 32'hd13b9e7e;
	cnd_pkg::cnd_frame_s rx_frame, sdo_rx_frame, rpdo_frame, tx_frame, f;
	cnd_pkg::cnd_frame_s sdo_seen, rpdo_seen;
	logic [63:0]         sent;
	cnd_pkg::cnd_state_e nmt_state;
	int                  mismatches = 0, checks = 0, sdo_hits = 0, rpdo_hits = 0, sync_hits = 0;

	cnd_dispatch #(.TIMER_CYCLES(20), .FIFO_DEPTH(32)) cnd_dispatch_inst (.clk_sys(clk_sys),
		.reset(reset), .node_switch(node_switch), .rx_frame(rx_frame), .rx_valid(rx_valid),
		.tpdo_mode(tpdo_mode), .timer_en(timer_en), .tpdo_data(tpdo_data), .tpdo_len(tpdo_len),
		.input_event(input_event), .app_event(app_event), .error_event(error_event),
		.error_code(error_code), .error_reg(error_reg), .sdo_tx_valid(sdo_tx_valid),
		.sdo_tx_data(sdo_tx_data), .sdo_tx_ready(sdo_tx_ready), .sdo_rx_frame(sdo_rx_frame),
		.sdo_rx_valid(sdo_rx_valid), .rpdo_frame(rpdo_frame), .rpdo_valid(rpdo_valid),
		.tx_frame(tx_frame), .tx_valid(tx_valid), .tx_ready(tx_ready), .nmt_state(nmt_state),
		.node_id(node_id), .node_id_bad(node_id_bad), .sync_seen(sync_seen));

	cnd_master #(.PAUSE(4)) m (.clk_sys(clk_sys), .hold(hold), .tx_frame(tx_frame),
		.tx_valid(tx_valid), .rx_frame(rx_frame), .rx_valid(rx_valid), .tx_ready(tx_ready));

	////////////////////////////////////////
	// Clock and counters of the one-cycle pulses.
	always #5 clk_sys = ~clk_sys;

	always @(posedge clk_sys) begin
		if (sdo_rx_valid === 1'b1) begin
			sdo_hits++;
			sdo_seen = sdo_rx_frame;
		end
		if (rpdo_valid === 1'b1) begin
			rpdo_hits++;
			rpdo_seen = rpdo_frame;
		end
		if (sync_seen === 1'b1) sync_hits++;
	end

	////////////////////////////////////////
	// Helpers that work out expectations and drive the inputs.
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [3:0] clip(input logic [3:0] n);
		return (n > 4'h8) ? 4'h8 : n;
	endfunction

	function automatic logic [63:0] keep(input logic [3:0] n);
		return (n == 4'h0) ? 64'h0 : ~64'h0 << (8 * (8 - n));
	endfunction

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task automatic ev(input bit app);
		if (app) app_event = 1'b1; else input_event = 1'b1;
		tick(1);
		app_event = 1'b0;
		input_event = 1'b0;
		tick(1);
	endtask

	task automatic wait_state(input cnd_pkg::cnd_state_e st);
		for (int k = 0; k < 300 && nmt_state !== st; k++) tick(1);
		`CHK(nmt_state, st)
	endtask

	task automatic expect_frame(input logic [10:0] cob, input logic [3:0] dlc,
			input logic [63:0] data);
		for (int k = 0; k < 200 && m.got.size() == 0; k++) tick(1);
		f = (m.got.size() > 0) ? m.got.pop_front() : '1;
		`CHK(f.cob, cob)
		`CHK(f.dlc, dlc)
		`CHK(f.data & keep(dlc), data & keep(dlc))
	endtask

	task automatic expect_none();
		tick(20);
		`CHK(m.got.size(), 0)
	endtask

	task automatic restart(input logic [7:0] sw);
		node_switch = sw;
		reset = 1'b1;
		tick(10);
		reset = 1'b0;
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	////////////////////////////////////////
	// Watchdog at 20000 cycles, well beyond the roughly 1200 cycles the sequence needs.
	initial begin
		#200000;
		mismatches++;
		test_done();
	end

	// Main sequence.
	initial begin
		id = 8'(rnd() % 127 + 1);
		node_switch = id;
		tick(10);
		reset = 1'b0;
		tick(50);
		`CHK(nmt_state, cnd_pkg::ST_INIT)
		wait_state(cnd_pkg::ST_PREOP);
		`CHK(node_id, id)
		`CHK(node_id_bad, 1'b0)
		ev(1'b0);
		expect_none();
		sent = {rnd(), rnd()};
		m.send(cnd_pkg::BASE_RSDO + 11'(id), 1'b0, 4'h8, sent);
		m.send(cnd_pkg::BASE_RPDO1 + 11'(id), 1'b0, 4'h8, {rnd(), rnd()});
		tick(3);
		`CHK(sdo_hits, 1)
		`CHK(sdo_seen.cob, cnd_pkg::BASE_RSDO + 11'(id))
		`CHK(sdo_seen.data, sent)
		`CHK(rpdo_hits, 0)
		sdo_tx_data = {rnd(), rnd()};
		sdo_tx_valid = 1'b1;
		for (int k = 0; k < 50; k++) begin
			@(posedge clk_sys);
			if (sdo_tx_ready === 1'b1) break;
		end
		#1;
		sdo_tx_valid = 1'b0;
		expect_frame(cnd_pkg::BASE_TSDO + 11'(id), 4'h8, sdo_tx_data);
		m.nmt(cnd_pkg::CS_START, 8'(id % 127 + 1));
		`CHK(nmt_state, cnd_pkg::ST_PREOP)
		m.nmt(cnd_pkg::CS_START, cnd_pkg::NODE_ALL);
		`CHK(nmt_state, cnd_pkg::ST_OPER)
		sent = {rnd(), rnd()};
		m.send(cnd_pkg::BASE_RPDO1 + 11'(id), 1'b0, 4'h8, sent);
		tick(3);
		`CHK(rpdo_hits, 1)
		`CHK(rpdo_seen.data, sent)
		for (int k = 0; k < 5; k++) begin
			tpdo_data = {rnd(), rnd()};
			tpdo_len = (k == 0) ? 4'hf : 4'(rnd());
			ev(1'b0);
			expect_frame(cnd_pkg::BASE_TPDO1 + 11'(id), clip(tpdo_len), tpdo_data);
		end
		m.send(cnd_pkg::BASE_TPDO1 + 11'(id), 1'b1, 4'h0, 64'h0);
		expect_frame(cnd_pkg::BASE_TPDO1 + 11'(id), clip(tpdo_len), tpdo_data);
		timer_en = 1'b1;
		tick(45);
		timer_en = 1'b0;
		tick(10);
		`CHK(m.got.size(), 2)
		m.got.delete();
		tpdo_mode = cnd_pkg::MODE_SYNC_CY;
		ev(1'b0);
		m.send(cnd_pkg::BASE_TPDO1 + 11'(id), 1'b1, 4'h0, 64'h0);
		expect_none();
		m.send(cnd_pkg::COB_SYNC, 1'b0, 4'h0, 64'h0);
		expect_frame(cnd_pkg::BASE_TPDO1 + 11'(id), clip(tpdo_len), tpdo_data);
		`CHK(sync_hits, 1)
		tpdo_mode = cnd_pkg::MODE_SYNC_AC;
		ev(1'b1);
		expect_frame(cnd_pkg::BASE_TPDO1 + 11'(id), clip(tpdo_len), tpdo_data);
		m.send(cnd_pkg::BASE_TPDO1 + 11'(id), 1'b1, 4'h0, 64'h0);
		expect_frame(cnd_pkg::BASE_TPDO1 + 11'(id), clip(tpdo_len), tpdo_data);
		tpdo_mode = cnd_pkg::MODE_EVENT;
		error_code = 16'(rnd());
		error_reg = 8'(rnd());
		error_event = 1'b1;
		expect_frame(cnd_pkg::BASE_EMCY + 11'(id), 4'h8,
			{error_code[7:0], error_code[15:8], error_reg, 40'h0});
		expect_none();
		error_event = 1'b0;
		hold = 1'b1;
		for (int k = 0; k < 40; k++) ev(1'b0);
		hold = 1'b0;
		tick(120);
		`CHK(m.got.size(), 33)
		m.got.delete();
		m.nmt(cnd_pkg::CS_STOP, id);
		`CHK(nmt_state, cnd_pkg::ST_STOP)
		m.nmt(cnd_pkg::CS_PREOP, id);
		`CHK(nmt_state, cnd_pkg::ST_PREOP)
		for (int k = 0; k < 2; k++) begin
			cs = k ? cnd_pkg::CS_RST_COMM : cnd_pkg::CS_RST_NODE;
			if (k) m.nmt(cnd_pkg::CS_START, id);
			m.nmt(cs, cnd_pkg::NODE_ALL);
			`CHK(nmt_state, cnd_pkg::ST_INIT)
			wait_state(cnd_pkg::ST_PREOP);
			expect_frame(cnd_pkg::BASE_GUARD + 11'(id), 4'h1, 64'h0);
		end
		restart(cnd_pkg::NODE_MAX);
		wait_state(cnd_pkg::ST_PREOP);
		m.nmt(cnd_pkg::CS_START, cnd_pkg::NODE_MAX);
		ev(1'b0);
		expect_frame(11'h1ff, clip(tpdo_len), tpdo_data);
		for (int k = 0; k < 2; k++) begin
			restart(k ? 8'h80 : 8'h00);
			tick(150);
			`CHK(node_id_bad, 1'b1)
			`CHK(nmt_state, cnd_pkg::ST_INIT)
		end
		test_done();
	end
endmodule
